// ### common/commission_map.vh
// Constants for the commissioning and discovery controller.
`ifndef COMMISSION_MAP_VH
`define COMMISSION_MAP_VH
// ----------------------------------------------------------------
// Timing figures, in their own units
// ----------------------------------------------------------------
`define CLK_HZ 50000000
`define PRESS_WINDOW_MS 2000
`define WAKE_LIMIT_MS 30000
`define BLINK_SHOW_MS 1000
`define BLINK_DEFAULT_MS 250
`define BLINK_UNIT_MS 10
`define BACKOFF_UNIT_MS 100
// ----------------------------------------------------------------
// Cycle counts derived from the figures
// ----------------------------------------------------------------
`define MS_CYC(ms) ((ms) * (`CLK_HZ / 1000))
`define PRESS_WINDOW_CYC `MS_CYC(`PRESS_WINDOW_MS)
`define WAKE_LIMIT_CYC `MS_CYC(`WAKE_LIMIT_MS)
`define BLINK_SHOW_CYC `MS_CYC(`BLINK_SHOW_MS)
`define BLINK_DEFAULT_CYC `MS_CYC(`BLINK_DEFAULT_MS)
`define BLINK_UNIT_CYC `MS_CYC(`BLINK_UNIT_MS)
`define BACKOFF_UNIT_CYC `MS_CYC(`BACKOFF_UNIT_MS)
// ----------------------------------------------------------------
// Press counts, settings, frame types, command kinds
// ----------------------------------------------------------------
`define PRESS_IDENTIFY 3'h1
`define PRESS_NOMINATE 3'h2
`define PRESS_RESTORE 3'h4
`define BUTTON_ON 1'h1
`define BACKOFF_RESET 8'h82
`define FRAME_NODE_ID 8'h95
`define FRAME_CMD_RESP 8'h88
`define FRAME_REMOTE_CMD 8'h17
`define KIND_DISCOVER 2'h0
`define KIND_FIND_DEST 2'h1
`define KIND_NEIGHBOR 2'h2
`endif

// ### design/commissioning_discovery_ctrl.v
// Commissioning pushbutton decoder and node discovery sequencer.
// Behaviour
// - Button works only when enable setting is one.
// - Presses grouped within two-second window give count.
// - Press while asleep wakes; ends cycle or 30s.
// - One press sends node identification broadcast.
// - Received identification blinks indicator for one second.
// - In API mode, received identification emits 0x95.
// - Two presses in synchronous sleep nominate coordinator.
// - Four presses restore and apply defaults.
// - Software press command acts like physical presses.
// - Unnamed discovery broadcasts; every node responds.
// - Command mode blocks commands, then extra return.
// - API mode keeps running; unnamed search silent without responses.
// - Broadcast carries backoff limit, default 0x82.
// - Named discovery ends at first match, else error.
// - Destination lookup loads address; in command mode OK, exits mode.
// - Lookup fails without name or on timeout.
// - Transparent lookup outputs no responder information.
// - Neighbor find zero-hop broadcast, replies as 0x88.
// - Remote neighbor find replies go to originator.
// - Zero blink period uses 250 ms default.
`timescale 1ns/1ps
`include "commission_map.vh"
module commissioning_discovery_ctrl #(
  parameter PRESS_WINDOW_CYC = `PRESS_WINDOW_CYC,
  parameter WAKE_LIMIT_CYC = `WAKE_LIMIT_CYC,
  parameter BLINK_SHOW_CYC = `BLINK_SHOW_CYC,
  parameter BLINK_DEFAULT_CYC = `BLINK_DEFAULT_CYC,
  parameter BLINK_UNIT_CYC = `BLINK_UNIT_CYC,
  parameter BACKOFF_UNIT_CYC = `BACKOFF_UNIT_CYC,
  parameter ADDR_W = 64
) (
  // Clock and reset.
  input wire mclk_in,
  input wire resetn_in,
  // Settings and device state.
  input wire commission_button_enable_in,
  input wire api_mode_in,
  input wire sync_sleep_net_in,
  input wire asleep_in,
  input wire sleep_cycle_end_in,
  input wire [7:0] indicator_blink_period_in,
  input wire [7:0] discovery_backoff_limit_in,
  // Pushbutton, low while pressed.
  input wire button_n_in,
  // Software press command.
  input wire simulated_press_command_in,
  input wire [2:0] press_count_in,
  // Discovery command from the host.
  input wire disc_valid_in,
  input wire [1:0] disc_kind_in,
  input wire name_present_in,
  input wire [7:0] origin_frame_in,
  output wire disc_ready_out,
  output wire cmd_allowed_out,
  // Radio receive side.
  input wire rx_node_id_in,
  input wire rx_resp_valid_in,
  input wire rx_resp_match_in,
  input wire [ADDR_W-1:0] rx_resp_addr_in,
  // Actions towards the radio and configuration.
  output reg wake_out,
  output reg tx_node_id_out,
  output reg tx_nominate_out,
  output reg restore_apply_out,
  output reg tx_disc_out,
  output reg tx_zero_hop_out,
  output reg tx_reply_direct_out,
  output reg [7:0] tx_backoff_out,
  output reg assoc_led_out,
  // Answers towards the host.
  output reg frame_valid_out,
  output reg [7:0] frame_type_out,
  output reg resp_fwd_out,
  output reg cr_out,
  output reg ok_out,
  output reg error_out,
  output reg exit_cmd_mode_out,
  output reg [ADDR_W-1:0] destination_address_out
);
  // ----------------------------------------------------------------
  // Press grouping
  // ----------------------------------------------------------------
  reg button_prev_r; // Last sampled button level.
  reg [31:0] window_r; // Cycles left in the grouping window.
  reg grouping_r; // A press group is open.
  reg [2:0] presses_r; // Presses in the open group, saturating.
  wire press = commission_button_enable_in == `BUTTON_ON
    && button_prev_r && !button_n_in;
  wire window_end = grouping_r && window_r == 32'h0;
  // The action count comes from either the closed group or software.
  wire act = window_end || simulated_press_command_in;
  wire [2:0] act_count = simulated_press_command_in ?
    press_count_in : presses_r;

  // Opens a group on the first press and counts until the window closes.
  // The window is measured from the first press, so late presses restart
  // nothing; they fall into the next group, except one on the closing cycle, which is dropped.
  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      button_prev_r <= 1'b1;
      window_r <= 32'h0;
      grouping_r <= 1'b0;
      presses_r <= 3'h0;
    end else begin
      button_prev_r <= button_n_in;
      if (grouping_r) begin
        if (window_r == 32'h0) begin
          grouping_r <= 1'b0;
        end else begin
          window_r <= window_r - 32'h1;
          if (press && presses_r != 3'h7) begin
            presses_r <= presses_r + 3'h1;
          end
        end
      end else if (press) begin
        grouping_r <= 1'b1;
        presses_r <= 3'h1;
        window_r <= PRESS_WINDOW_CYC - 1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Press actions
  // ----------------------------------------------------------------
  // One-cycle pulses; counts other than one, two and four do nothing.
  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      tx_node_id_out <= 1'b0;
      tx_nominate_out <= 1'b0;
      restore_apply_out <= 1'b0;
    end else begin
      tx_node_id_out <= act && act_count == `PRESS_IDENTIFY;
      tx_nominate_out <= act && act_count == `PRESS_NOMINATE
        && sync_sleep_net_in;
      restore_apply_out <= act && act_count == `PRESS_RESTORE;
      // Any other count falls through here unanswered.
    end
  end

  // ----------------------------------------------------------------
  // Wake on press
  // ----------------------------------------------------------------
  reg [31:0] wake_cnt_r; // Cycles left in the wake period.

  // Seniority is settled by the sleep logic outside; this block only
  // holds the device awake, capped at the wake limit.
  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      wake_out <= 1'b0;
      wake_cnt_r <= 32'h0;
    end else if (press && asleep_in && !wake_out) begin
      wake_out <= 1'b1;
      wake_cnt_r <= WAKE_LIMIT_CYC - 1;
    end else if (wake_out) begin
      if (sleep_cycle_end_in || wake_cnt_r == 32'h0) begin
        wake_out <= 1'b0;
      end else begin
        wake_cnt_r <= wake_cnt_r - 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Indicator blink on received identification
  // ----------------------------------------------------------------
  reg [31:0] show_r; // Cycles left in the blink show.
  reg [31:0] half_r; // Cycles left in the current blink half.
  reg blinking_r; // The show is running.
  wire [31:0] half_len = (indicator_blink_period_in == 8'h0) ?
    BLINK_DEFAULT_CYC :
    indicator_blink_period_in * BLINK_UNIT_CYC;

  // Outside a show the indicator stays lit as a power sign.
  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      show_r <= 32'h0;
      half_r <= 32'h0;
      blinking_r <= 1'b0;
      assoc_led_out <= 1'b1;
    end else if (rx_node_id_in) begin
      blinking_r <= 1'b1;
      show_r <= BLINK_SHOW_CYC - 1;
      half_r <= half_len - 32'h1;
      assoc_led_out <= 1'b0;
    end else if (blinking_r) begin
      if (show_r == 32'h0) begin
        blinking_r <= 1'b0;
        assoc_led_out <= 1'b1;
      end else begin
        show_r <= show_r - 32'h1;
        if (half_r == 32'h0) begin
          half_r <= half_len - 32'h1;
          assoc_led_out <= !assoc_led_out;
        end else begin
          half_r <= half_r - 32'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Discovery sequencer
  // ----------------------------------------------------------------
  localparam ST_IDLE = 1'b0; // No discovery pending.
  localparam ST_WAIT = 1'b1; // Waiting for responses or timeout.
  reg state_r; // Sequencer state.
  reg [1:0] kind_r; // Kind of the pending command.
  reg named_r; // The pending command carries a name and is not a neighbor find.
  reg api_r; // Mode captured when the command was taken.
  reg [31:0] tick_r; // Cycles left in the current backoff unit.
  reg [7:0] units_r; // Backoff units left before timeout.
  wire take = disc_valid_in && state_r == ST_IDLE;
  wire timeout = tick_r == 32'h0 && units_r == 8'h0;
  wire resp = rx_resp_valid_in && state_r == ST_WAIT;
  // A named search only looks at matching responses.
  wire hit = resp && (!named_r || rx_resp_match_in);

  assign disc_ready_out = state_r == ST_IDLE;
  // Command mode holds other commands off until discovery is over.
  assign cmd_allowed_out = state_r == ST_IDLE || api_mode_in;

  // Takes a command, broadcasts it, then gathers responses until the
  // backoff window expires or a named search matches. Mode is captured at the start so a mode
  // change mid-search cannot split the answer between two formats.
  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      state_r <= ST_IDLE;
      kind_r <= `KIND_DISCOVER;
      named_r <= 1'b0;
      api_r <= 1'b0;
      tick_r <= 32'h0;
      units_r <= 8'h0;
      tx_disc_out <= 1'b0;
      tx_zero_hop_out <= 1'b0;
      tx_reply_direct_out <= 1'b0;
      tx_backoff_out <= `BACKOFF_RESET;
      resp_fwd_out <= 1'b0;
      cr_out <= 1'b0;
      ok_out <= 1'b0;
      error_out <= 1'b0;
      exit_cmd_mode_out <= 1'b0;
      destination_address_out <= {ADDR_W{1'b0}};
    end else begin
      tx_disc_out <= 1'b0;
      resp_fwd_out <= 1'b0;
      cr_out <= 1'b0;
      ok_out <= 1'b0;
      error_out <= 1'b0;
      exit_cmd_mode_out <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (take) begin
            if (disc_kind_in == `KIND_FIND_DEST && !name_present_in) begin
              error_out <= 1'b1;
            end else begin
              state_r <= ST_WAIT;
              kind_r <= disc_kind_in;
              named_r <= name_present_in && disc_kind_in != `KIND_NEIGHBOR;
              api_r <= api_mode_in;
              tick_r <= BACKOFF_UNIT_CYC - 1;
              units_r <= discovery_backoff_limit_in;
              tx_disc_out <= 1'b1;
              tx_backoff_out <= discovery_backoff_limit_in;
              tx_zero_hop_out <= disc_kind_in == `KIND_NEIGHBOR;
              tx_reply_direct_out <= disc_kind_in == `KIND_NEIGHBOR
                && origin_frame_in == `FRAME_REMOTE_CMD;
            end
          end
        end
        ST_WAIT: begin
          if (hit && named_r) begin
            // First match closes a named search.
            state_r <= ST_IDLE;
            if (kind_r == `KIND_FIND_DEST) begin
              destination_address_out <= rx_resp_addr_in;
              resp_fwd_out <= api_r;
              ok_out <= !api_r;
              exit_cmd_mode_out <= !api_r;
            end else begin
              resp_fwd_out <= 1'b1;
              cr_out <= !api_r;
            end
          end else if (timeout) begin
            state_r <= ST_IDLE;
            error_out <= named_r;
            cr_out <= !named_r && !api_r;
          end else begin
            resp_fwd_out <= hit;
            if (tick_r == 32'h0) begin
              tick_r <= BACKOFF_UNIT_CYC - 1;
              units_r <= units_r - 8'h1;
            end else begin
              tick_r <= tick_r - 32'h1;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // API frame marker
  // ----------------------------------------------------------------
  // Marks each API frame for the serial formatter. Identification wins
  // a same-cycle clash; the response is still flagged on resp_fwd_out.
  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      frame_valid_out <= 1'b0;
      frame_type_out <= 8'h00;
    end else if (rx_node_id_in && api_mode_in) begin
      frame_valid_out <= 1'b1;
      frame_type_out <= `FRAME_NODE_ID;
    end else if (hit && api_r) begin
      frame_valid_out <= 1'b1;
      frame_type_out <= `FRAME_CMD_RESP;
    end else begin
      frame_valid_out <= 1'b0;
    end
  end
endmodule

// ### tb/ctrl_props.sv
// Concurrent checks on the ports of the commissioning controller.
`timescale 1ns/1ps
module ctrl_props (
  // Clock and reset.
  input wire mclk_in,
  input wire resetn_in,
  // Inputs that cause actions.
  input wire sync_sleep_net_in,
  input wire api_mode_in,
  input wire simulated_press_command_in,
  input wire [2:0] press_count_in,
  input wire disc_valid_in,
  input wire [1:0] disc_kind_in,
  input wire name_present_in,
  input wire [7:0] discovery_backoff_limit_in,
  input wire rx_node_id_in,
  // Outputs under watch.
  input wire disc_ready_out,
  input wire tx_node_id_out,
  input wire tx_nominate_out,
  input wire restore_apply_out,
  input wire tx_disc_out,
  input wire tx_zero_hop_out,
  input wire [7:0] tx_backoff_out,
  input wire assoc_led_out,
  input wire frame_valid_out,
  input wire [7:0] frame_type_out,
  input wire ok_out,
  input wire error_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // A request counts only when the sequencer is idle to take it.
  wire take = disc_valid_in && disc_ready_out;
  wire no_name = disc_kind_in == 2'h1 && !name_present_in;
  wire sp = simulated_press_command_in;
  wire any_act = tx_node_id_out || tx_nominate_out || restore_apply_out;
  property p_identify; sp && press_count_in == 3'h1 |=> tx_node_id_out;
  endproperty
  a_identify: assert property (p_identify) else $error("no identify");
  property p_nominate; sp && press_count_in == 3'h2 |=>
    tx_nominate_out == $past(sync_sleep_net_in); endproperty
  a_nominate: assert property (p_nominate) else $error("bad nominate");
  property p_restore; sp && press_count_in == 3'h4 |=> restore_apply_out;
  endproperty
  a_restore: assert property (p_restore) else $error("no restore");
  property p_ignore; sp && !(press_count_in inside {3'h1, 3'h2, 3'h4}) |=>
    !any_act; endproperty
  a_ignore: assert property (p_ignore) else $error("stray action");
  property p_start; take && !no_name |=> tx_disc_out && !error_out;
  endproperty
  a_start: assert property (p_start) else $error("no broadcast");
  property p_noname; take && no_name |=> error_out && !tx_disc_out;
  endproperty
  a_noname: assert property (p_noname) else $error("no error");
  property p_backoff; tx_disc_out |->
    tx_backoff_out == $past(discovery_backoff_limit_in); endproperty
  a_backoff: assert property (p_backoff) else $error("bad backoff");
  property p_zero_hop; tx_disc_out |->
    tx_zero_hop_out == ($past(disc_kind_in) == 2'h2); endproperty
  a_zero_hop: assert property (p_zero_hop) else $error("bad hops");
  property p_blink; rx_node_id_in |=> !assoc_led_out; endproperty
  a_blink: assert property (p_blink) else $error("no blink");
  property p_api_frame; rx_node_id_in && api_mode_in |=>
    frame_valid_out && frame_type_out == 8'h95; endproperty
  a_api_frame: assert property (p_api_frame) else $error("no frame");
  // Main scenarios that the bench must reach.
  c_lookup: cover property (tx_disc_out ##[1:60] ok_out);
  c_noname: cover property (take && no_name);
  c_blink: cover property (rx_node_id_in ##1 !assoc_led_out);
endmodule

// ### tb/peer_model.sv
// Behavioural peer nodes that answer discovery broadcasts.
`timescale 1ns/1ps
module peer_model (
  input wire mclk_in,
  input wire tx_disc_in,
  input wire [2:0] n_resp_in,
  input wire match_in,
  output reg rx_resp_valid_out,
  output reg rx_resp_match_out,
  output reg [63:0] rx_resp_addr_out
);
  integer seed = 5;
  integer i;
  // Idle lines flip each cycle while no broadcast is being answered, so a stale value never passes for news.
  initial begin
    rx_resp_valid_out = 1'b0;
    rx_resp_match_out = 1'b0;
    rx_resp_addr_out = 64'h0;
    forever begin
      @(posedge mclk_in);
      rx_resp_addr_out <= ~rx_resp_addr_out;
      rx_resp_match_out <= ~rx_resp_match_out;
      if (tx_disc_in) begin
        // Every node answers once, after a random wait in the window.
        for (i = 0; i < n_resp_in; i = i + 1) begin
          repeat (1 + {$random(seed)} % 4) @(posedge mclk_in);
          rx_resp_valid_out <= 1'b1;
          rx_resp_match_out <= match_in;
          rx_resp_addr_out <= {$random(seed), $random(seed)};
          @(posedge mclk_in);
          rx_resp_valid_out <= 1'b0;
          rx_resp_match_out <= ~match_in;
        end
      end
    end
  end
endmodule

// ### tb/tb.sv
// Self-checking bench for the commissioning and discovery controller.
`timescale 1ns/1ps
bind commissioning_discovery_ctrl ctrl_props props (.*);
module tb;
  // Design inputs, all given a value at time zero.
  reg mclk_in = 1'b0;
  reg resetn_in = 1'b0;
  reg commission_button_enable_in = 1'b1;
  reg api_mode_in = 1'b0;
  reg sync_sleep_net_in = 1'b0;
  reg asleep_in = 1'b0;
  reg sleep_cycle_end_in = 1'b0;
  reg [7:0] indicator_blink_period_in = 8'h00;
  reg [7:0] discovery_backoff_limit_in = 8'h05;
  reg button_n_in = 1'b1;
  reg simulated_press_command_in = 1'b0;
  reg [2:0] press_count_in = 3'h0;
  reg disc_valid_in = 1'b0;
  reg [1:0] disc_kind_in = 2'h0;
  reg name_present_in = 1'b0;
  reg [7:0] origin_frame_in = 8'h17;
  reg rx_node_id_in = 1'b0;
  wire rx_resp_valid_in, rx_resp_match_in;
  wire [63:0] rx_resp_addr_in;
  // Design outputs.
  wire disc_ready_out, cmd_allowed_out, wake_out, tx_node_id_out;
  wire tx_nominate_out, restore_apply_out, tx_disc_out, tx_zero_hop_out;
  wire tx_reply_direct_out, assoc_led_out, frame_valid_out, resp_fwd_out;
  wire cr_out, ok_out, error_out, exit_cmd_mode_out;
  wire [7:0] tx_backoff_out, frame_type_out;
  wire [63:0] destination_address_out;
  // Bench state and counters.
  reg [2:0] n_resp = 3'h0;
  reg resp_match = 1'b0;
  reg [2:0] acc;
  reg [31:0] rnd;
  reg [63:0] addr_m;
  integer seed = 67;
  integer failures = 0;
  integer n_compared = 0;
  integer i, k, t, h, c_fwd, c_cr, c_ok, c_ex, c_err, c_fr, ef, ec, eo, ee;
  // Short counts keep the run brief; expectations use the same figures.
  commissioning_discovery_ctrl #(.PRESS_WINDOW_CYC(20), .WAKE_LIMIT_CYC(50),
    .BLINK_SHOW_CYC(40), .BLINK_DEFAULT_CYC(4), .BLINK_UNIT_CYC(2),
    .BACKOFF_UNIT_CYC(5)) dut (.*);
  peer_model peer (.mclk_in(mclk_in), .tx_disc_in(tx_disc_out),
    .n_resp_in(n_resp), .match_in(resp_match),
    .rx_resp_valid_out(rx_resp_valid_in), .rx_resp_match_out(rx_resp_match_in),
    .rx_resp_addr_out(rx_resp_addr_in));
  initial begin
    forever #10 mclk_in = ~mclk_in;
  end
  task chk(input [63:0] seen, input [63:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // A wait that runs out is a mismatch and ends the run.
  task lim_hit;
    begin
      failures = failures + 1;
      print_verdict;
    end
  endtask
  // Expected actions {restore, nominate, identify} for a press count.
  function [2:0] act(input integer n);
    act = {n == 4, n == 2 && sync_sleep_net_in, n == 1};
  endfunction
  // Presses n times inside one window, then watches for the action.
  task group(input integer n, input en_v);
    begin
      @(posedge mclk_in) commission_button_enable_in <= en_v;
      for (k = 0; k < n; k = k + 1) begin
        @(posedge mclk_in) button_n_in <= 1'b0;
        @(posedge mclk_in) button_n_in <= 1'b1;
        #1 if (k == 0 && asleep_in) chk(wake_out, 1'b1);
      end
      acc = 3'h0;
      repeat (40) begin
        @(posedge mclk_in);
        #1 acc = acc | {restore_apply_out, tx_nominate_out, tx_node_id_out};
      end
      chk(acc, en_v ? act(n) : 3'h0);
    end
  endtask
  // One discovery request, peers answering; answers are tallied.
  task disc(input [1:0] kd, input nm, input ap, input [2:0] nr, input mt);
    reg nmd;
    begin
      nmd = nm && kd != 2'h2;
      @(posedge mclk_in) begin
        disc_valid_in <= 1'b1;
        disc_kind_in <= kd;
        name_present_in <= nm;
        api_mode_in <= ap;
        n_resp <= nr;
        resp_match <= mt;
        discovery_backoff_limit_in <= 8'h05 + rnd[1:0];
        // Remote and local origins both occur, so direct replies are tested.
        origin_frame_in <= rnd[5] ? 8'h17 : 8'h08;
      end
      @(posedge mclk_in) disc_valid_in <= 1'b0;
      #1 if (kd != 2'h1 || nm) begin
        chk(cmd_allowed_out, ap);
        chk(tx_reply_direct_out, kd == 2'h2 && rnd[5]);
      end
      {c_fwd, c_cr, c_ok, c_ex, c_err, c_fr, addr_m, k} = 0;
      for (t = 0; t < 200 && k < 3; t = t + 1) begin
        if (rx_resp_valid_in && rx_resp_match_in && addr_m === 64'h0)
          addr_m = rx_resp_addr_in;
        c_fwd = c_fwd + resp_fwd_out;
        c_cr = c_cr + cr_out;
        c_ok = c_ok + ok_out;
        c_ex = c_ex + exit_cmd_mode_out;
        c_err = c_err + error_out;
        c_fr = c_fr + (frame_valid_out && frame_type_out == 8'h88);
        k = disc_ready_out ? k + 1 : 0;
        @(posedge mclk_in);
        #1;
      end
      if (t == 200) lim_hit;
      {ef, ec, eo, ee} = 0;
      if ((kd == 2'h1 && !nm) || (nmd && !mt)) ee = 1;
      else if (kd == 2'h1) {ef, eo} = {ap ? 1 : 0, ap ? 0 : 1};
      else {ef, ec} = {nmd ? 1 : nr, ap ? 0 : 1};
      // Every forwarded response is also an API frame, but only in API mode.
      chk({c_fwd[3:0], c_fr[3:0]},
        {ef[3:0], (ap ? ef[3:0] : 4'h0)});
      chk({c_cr[3:0], c_ok[3:0], c_ex[3:0], c_err[3:0]},
        {ec[3:0], eo[3:0], eo[3:0], ee[3:0]});
      if (kd == 2'h1 && nm && mt) chk(destination_address_out, addr_m);
    end
  endtask
  initial begin
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'b1;
    @(posedge mclk_in);
    #1 chk({assoc_led_out, disc_ready_out, tx_backoff_out}, 10'h382);
    chk(destination_address_out, 64'h0);
    $display("reset test done");
    for (i = 0; i < 8; i = i + 1) begin
      rnd = $random(seed);
      @(posedge mclk_in) begin
        simulated_press_command_in <= 1'b1;
        press_count_in <= i;
        sync_sleep_net_in <= rnd[0];
      end
      @(posedge mclk_in) simulated_press_command_in <= 1'b0;
      #1 chk({restore_apply_out, tx_nominate_out, tx_node_id_out}, act(i));
    end
    $display("software press test done");
    @(posedge mclk_in) asleep_in <= 1'b1;
    for (i = 1; i < 6; i = i + 1) begin
      rnd = $random(seed);
      @(posedge mclk_in) sync_sleep_net_in <= rnd[0];
      group(i == 5 ? 1 : i, i != 5);
      // The first group runs into the wake limit; the second is cut short
      // by the end of the sleep cycle, some six cycles before that limit.
      if (i < 3) begin
        if (i == 2) @(posedge mclk_in) sleep_cycle_end_in <= 1'b1;
        for (t = 0; t < (i == 2 ? 3 : 15) && wake_out; t = t + 1)
          @(posedge mclk_in);
        #1 chk(wake_out, 1'b0);
        @(posedge mclk_in) begin
          asleep_in <= (i == 1);
          sleep_cycle_end_in <= 1'b0;
        end
      end
    end
    $display("button test done");
    for (i = 0; i < 2; i = i + 1) begin
      h = i ? 6 : 4;
      @(posedge mclk_in) begin
        indicator_blink_period_in <= i * 3;
        api_mode_in <= i;
        rx_node_id_in <= 1'b1;
      end
      @(posedge mclk_in) rx_node_id_in <= 1'b0;
      #1 chk({assoc_led_out, frame_valid_out}, i);
      c_fr = 0;
      for (t = 0; t < 60; t = t + 1) begin
        k = assoc_led_out;
        @(posedge mclk_in);
        #1 c_fr = c_fr + (assoc_led_out !== k);
      end
      chk(c_fr >= 40 / h - 1 && c_fr <= 40 / h + 1 && assoc_led_out, 1);
    end
    $display("blink test done");
    for (i = 0; i < 24; i = i + 1) begin
      rnd = $random(seed);
      disc(i % 3, (i / 3) % 2, (i / 6) % 2,
        ((i / 3) % 2 && i % 3 != 2) ? 3'h1 : rnd[4:2] % 5, i < 12);
    end
    $display("discovery test done");
    print_verdict;
  end
endmodule
